// ==== src/sac_consts.svh ====
// sac_consts.svh - offsets, field positions and timing counts of the converter control
// assumes: included by bare name; holds macro definitions only
// Behaviour
// - eight-input mux feeds one 10-bit SAR
// - external start off: software set starts only
// - external start on: software or pin edge
// - pin edge seen at cycle end, starts next
// - software start begins at next machine cycle
// - start bit is command and status flops
// - two init cycles; status set after first
// - sample selected input for eight cycles
// - try msb first, keep bit if input higher
// - four machine cycles per result bit
// - upper eight in result, low two in control
// - done set, status cleared after 50 cycles
// - three select bits pick input zero..seven
// - starts ignored while conversion running
// - idle or power-down aborts; result kept
// - done flag blocks starts, raises interrupt
// - start bit not clearable by software
`ifndef SAC_CONSTS_SVH
`define SAC_CONSTS_SVH

// machine cycle: clocks per cycle and terminal count
`define SAC_MC_DIV 4'hc
`define SAC_MC_LAST 4'hb

// conversion phase points, in machine cycles from the start
`define SAC_N_STATUS 6'h01
`define SAC_N_SAMPLE 6'h02
`define SAC_N_CONVERT 6'h0a
`define SAC_N_DONE 6'h32
`define SAC_N_DONE_RED 6'h18
`define SAC_BIT_MASK 6'h03

// approximation register
`define SAC_SAR_MSB_ONLY 10'h200
`define SAC_PTR_MSB 4'h9

// register indices; byte address is four times the index
`define SAC_IDX_CTRL 8'hc5
`define SAC_IDX_RESULT 8'hc6
`define SAC_IDX_ISTAT 8'hc7
`define SAC_IDX_IMASK 8'hc8
`define SAC_IDX_POWER 8'hc9

// control and power register fields
`define SAC_B_START 3
`define SAC_B_DONE 4
`define SAC_B_EXT 5
`define SAC_B_IDLE 0
`define SAC_B_PDOWN 1

// reset values
`define SAC_CTRL_RST 8'h00
`define SAC_RD_RST 32'h0000_0000

`endif

// ==== src/sac_mcycle.sv ====
// sac_mcycle.sv - machine-cycle enable from the controller clock
// assumes: synchronous reset copy from the top, one clock domain
`timescale 1ns/1ps
`default_nettype none
`include "sac_consts.svh"
module sac_mcycle
  import sac_pkg::*;
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // one-clock pulse at the end of each machine cycle
  output logic tick_o
);
  sac_mc_s r; // divider state
  sac_mc_s nxt; // next divider state

  // free-running divider; every phase counts these ticks
  always_comb begin
    nxt = r;
    nxt.tick = 1'b0;
    if (r.cnt == `SAC_MC_LAST) begin
      nxt.cnt = 4'h0;
      nxt.tick = 1'b1;
    end else begin
      nxt.cnt = 4'(r.cnt + 4'h1);
    end
  end

  // state register
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r <= '0;
    end else begin
      r <= nxt;
    end
  end

  assign tick_o = r.tick;
endmodule : sac_mcycle
`default_nettype wire

// ==== src/sac_pkg.sv ====
// sac_pkg.sv - types shared by the converter control modules
// assumes: sac_consts.svh on the include path
`include "sac_consts.svh"
package sac_pkg;
  // conversion phases
  typedef enum logic [1:0] {PH_IDLE, PH_INIT, PH_SAMPLE, PH_CONVERT} sac_phase_e;

  // machine-cycle divider state
  typedef struct packed {
    logic [3:0] cnt;
    logic tick;
  } sac_mc_s;

  // approximation register state
  typedef struct packed {
    logic [9:0] trial;
    logic [3:0] ptr;
  } sac_sar_s;

  // top-level state
  typedef struct packed {
    logic waitreq;
    logic [31:0] rdata;
    logic ext_s1;
    logic ext_s2;
    logic ext_prev;
    logic comp_s1;
    logic comp_s2;
    logic [2:0] chan;
    logic ext_en;
    logic done;
    logic cmd;
    logic status;
    logic [9:0] result;
    sac_phase_e phase;
    logic [5:0] mcnt;
    logic sample;
    logic idle_req;
    logic pdown_req;
    logic [1:0] istat;
    logic [1:0] imask;
    logic irq;
  } sac_top_s;
endpackage : sac_pkg

// ==== src/sac_sar.sv ====
// sac_sar.sv - successive approximation register and bit pointer
// assumes: load and decide are single-clock pulses from the top
`timescale 1ns/1ps
`default_nettype none
`include "sac_consts.svh"
module sac_sar
  import sac_pkg::*;
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // sequencing from the top
  input wire logic load_i,
  input wire logic decide_i,
  input wire logic comp_i,
  // trial code to the dac
  output logic [9:0] trial_o
);
  sac_sar_s r; // register and pointer
  sac_sar_s nxt; // next value

  // load msb only, then keep or drop each tested bit
  always_comb begin
    nxt = r;
    if (load_i) begin
      nxt.trial = `SAC_SAR_MSB_ONLY;
      nxt.ptr = `SAC_PTR_MSB;
    end else if (decide_i) begin
      // keep the bit only while the input beats the dac
      if (!comp_i) begin
        nxt.trial[r.ptr] = 1'b0;
      end
      // move to the next lower bit; pointer stops at zero
      if (r.ptr != 4'h0) begin
        nxt.trial[4'(r.ptr - 4'h1)] = 1'b1;
        nxt.ptr = 4'(r.ptr - 4'h1);
      end
    end
  end

  // state register
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r <= '0;
    end else begin
      r <= nxt;
    end
  end

  assign trial_o = r.trial;
endmodule : sac_sar
`default_nettype wire

// ==== src/sac_top.sv ====
// sac_top.sv - converter control: registers, start logic, phase sequencer
// assumes: avalon-mm master on mclk_i, comparator and trigger pin asynchronous
`timescale 1ns/1ps
`default_nettype none
`include "sac_consts.svh"
module sac_top
  import sac_pkg::*;
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // avalon-mm slave, byte address
  input wire logic [9:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // trigger pin and comparator
  input wire logic external_trigger_pin_i,
  input wire logic comparator_i,
  // analog front end control
  output logic [2:0] analog_input_port_sel_o,
  output logic sample_o,
  output logic [9:0] dac_code_o,
  // interrupt
  output logic irq_o
);
  // ------------------------------------------------------------------
  // reset release
  // ------------------------------------------------------------------
  logic [1:0] rst_sync_r; // release chain
  logic rst_n_s; // synchronous copy of the reset

  // assert at once, release after two edges
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n_s = rst_sync_r[1];

  // ------------------------------------------------------------------
  // state and helpers
  // ------------------------------------------------------------------
  sac_top_s r; // all block state
  sac_top_s nxt; // next state
  logic mc_tick; // end of a machine cycle
  logic [7:0] idx; // register index from the byte address
  logic acc; // request seen, answer next clock
  logic wr_go; // write takes effect this edge
  logic [7:0] wdat; // low byte of write data
  logic [5:0] n; // machine cycle about to complete
  logic start_ok; // no conversion, no result pending
  logic sw_start; // software sets the start bit
  logic ext_edge; // qualified rising edge on the pin
  logic abort; // low-power entry with a conversion running
  logic load; // load msb trial
  logic decide; // decide the bit under test
  logic finish; // last bit decided this tick

  // register read mux; reserved bits read zero
  function automatic logic [7:0] rd_byte(input sac_top_s s, input logic [7:0] a);
    case (a)
      `SAC_IDX_CTRL: rd_byte = {s.result[1:0], s.ext_en, s.done, s.status, s.chan};
      `SAC_IDX_RESULT: rd_byte = s.result[9:2];
      `SAC_IDX_ISTAT: rd_byte = {6'h00, s.istat};
      `SAC_IDX_IMASK: rd_byte = {6'h00, s.imask};
      `SAC_IDX_POWER: rd_byte = {6'h00, s.pdown_req, s.idle_req};
      default: rd_byte = 8'h00;
    endcase
  endfunction : rd_byte

  // true at the end of each four-cycle bit slot
  function automatic logic bit_end(input logic [5:0] c);
    bit_end = (c > `SAC_N_CONVERT) && ((6'(c - `SAC_N_CONVERT) & `SAC_BIT_MASK) == 6'h00);
  endfunction : bit_end

  // ------------------------------------------------------------------
  // submodules
  // ------------------------------------------------------------------
  // machine-cycle enable paces every phase
  sac_mcycle u_mcycle (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_s),
    .tick_o(mc_tick)
  );

  // approximation register drives the dac code directly
  sac_sar u_sar (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_s),
    .load_i(load),
    .decide_i(decide),
    .comp_i(r.comp_s2),
    .trial_o(dac_code_o)
  );

  // ------------------------------------------------------------------
  // next-state logic
  // ------------------------------------------------------------------
  always_comb begin
    nxt = r;
    idx = avs_address_i[9:2];
    acc = (avs_read_i | avs_write_i) & r.waitreq;
    wr_go = avs_write_i & ~r.waitreq & avs_byteenable_i[0];
    wdat = avs_writedata_i[7:0];
    n = 6'(r.mcnt + 6'h01);
    load = 1'b0;
    decide = 1'b0;
    finish = 1'b0;
    // starts only with nothing running and no result waiting
    start_ok = ~r.cmd & ~r.status & ~r.done & ~r.idle_req & ~r.pdown_req;
    sw_start = wr_go && (idx == `SAC_IDX_CTRL) && wdat[`SAC_B_START];
    // pin level compared once per machine cycle, so a low and a high
    // of one machine cycle each make exactly one edge
    ext_edge = r.ext_en & mc_tick & ~r.ext_prev & r.ext_s2;
    abort = (r.idle_req | r.pdown_req) & r.cmd;

    // pin and comparator synchronisers
    nxt.ext_s1 = external_trigger_pin_i;
    nxt.ext_s2 = r.ext_s1;
    nxt.comp_s1 = comparator_i;
    nxt.comp_s2 = r.comp_s1;
    if (mc_tick) begin
      nxt.ext_prev = r.ext_s2;
    end

    // bus answer: one wait-free clock after the request is seen
    if (acc) begin
      nxt.waitreq = 1'b0;
      nxt.rdata = {24'h000000, rd_byte(r, idx)};
    end else begin
      nxt.waitreq = 1'b1;
    end

    // register writes
    if (wr_go) begin
      case (idx)
        `SAC_IDX_CTRL: begin
          nxt.chan = wdat[2:0];
          nxt.ext_en = wdat[`SAC_B_EXT];
          // writing zero clears done; the start bit ignores zero
          if (!wdat[`SAC_B_DONE]) begin
            nxt.done = 1'b0;
          end
        end
        `SAC_IDX_ISTAT: begin
          nxt.istat = r.istat & ~wdat[1:0];
        end
        `SAC_IDX_IMASK: begin
          nxt.imask = wdat[1:0];
        end
        `SAC_IDX_POWER: begin
          nxt.idle_req = wdat[`SAC_B_IDLE];
          nxt.pdown_req = wdat[`SAC_B_PDOWN];
        end
        default: begin
          // unmapped: write ignored
        end
      endcase
    end

    // command flop: loaded by set operations only
    if (start_ok && (sw_start || ext_edge)) begin
      nxt.cmd = 1'b1;
    end

    // phase sequencer, advanced by machine-cycle ticks only
    if (abort) begin
      // result and done flag untouched; only the run is dropped
      nxt.cmd = 1'b0;
      nxt.status = 1'b0;
      nxt.sample = 1'b0;
      nxt.phase = PH_IDLE;
      nxt.mcnt = 6'h00;
      nxt.istat[1] = 1'b1;
    end else if (mc_tick) begin
      case (r.phase)
        PH_IDLE: begin
          // software start waits for this tick; a pin edge starts here
          if (r.cmd || (start_ok && ext_edge)) begin
            nxt.phase = PH_INIT;
            nxt.mcnt = 6'h00;
          end
        end
        PH_INIT: begin
          nxt.mcnt = n;
          if (n == `SAC_N_STATUS) begin
            nxt.status = 1'b1;
          end
          if (n == `SAC_N_SAMPLE) begin
            nxt.phase = PH_SAMPLE;
            nxt.sample = 1'b1;
          end
        end
        PH_SAMPLE: begin
          nxt.mcnt = n;
          if (n == `SAC_N_CONVERT) begin
            nxt.sample = 1'b0;
            nxt.phase = PH_CONVERT;
            load = 1'b1;
          end
        end
        PH_CONVERT: begin
          nxt.mcnt = n;
          decide = bit_end(n);
          if (n == `SAC_N_DONE) begin
            // last bit resolved here, straight from the comparator
            finish = 1'b1;
            nxt.result = {dac_code_o[9:1], r.comp_s2};
            nxt.done = 1'b1;
            nxt.status = 1'b0;
            nxt.cmd = 1'b0;
            nxt.phase = PH_IDLE;
            nxt.istat[0] = 1'b1;
          end
        end
        default: begin
          nxt.phase = PH_IDLE;
        end
      endcase
    end

    // level interrupt from masked sticky bits
    nxt.irq = |(r.istat & r.imask);
  end

  // ------------------------------------------------------------------
  // state register
  // ------------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rst_n_s) begin
    if (!rst_n_s) begin
      r <= '0;
      r.waitreq <= 1'b1;
      r.rdata <= `SAC_RD_RST;
      r.phase <= PH_IDLE;
      {r.result[1:0], r.ext_en, r.done, r.status, r.chan} <= `SAC_CTRL_RST;
      // previous pin level starts high, so a pin that idles high cannot pass
      // for a rising edge at the first tick after reset
      r.ext_prev <= 1'b1;
    end else begin
      r <= nxt;
    end
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  assign avs_readdata_o = r.rdata;
  assign avs_waitrequest_o = r.waitreq;
  assign analog_input_port_sel_o = r.chan;
  assign sample_o = r.sample;
  assign irq_o = r.irq;

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  default clocking sac_cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n_s);

  a_status_set:
    assert property (mc_tick && !abort && r.phase == PH_INIT && n == `SAC_N_STATUS
      |=> r.status && r.mcnt == `SAC_N_STATUS)
    else $error("status flag not set after first cycle");

  a_sample_open:
    assert property ($rose(r.sample) |-> r.mcnt == `SAC_N_SAMPLE && r.phase == PH_SAMPLE)
    else $error("sampling opened at wrong cycle");

  a_sample_close:
    assert property ($fell(r.sample) && !$past(abort) |-> r.mcnt == `SAC_N_CONVERT)
    else $error("sampling window not eight cycles");

  a_done_count:
    assert property ($rose(r.done) |-> r.mcnt == `SAC_N_DONE
      && $past(r.mcnt) == 6'(`SAC_N_DONE - 6'h01))
    else $error("done not at fiftieth cycle");

  a_done_clears:
    assert property ($rose(r.done) |-> !r.status && !r.cmd && r.phase == PH_IDLE)
    else $error("start bit still set with done");

  a_done_blocks:
    assert property (r.done |=> !$rose(r.cmd))
    else $error("start accepted while done set");

  a_busy_holds:
    assert property (r.cmd && !abort && !finish |=> r.cmd)
    else $error("running conversion disturbed");

  a_abort_run:
    assert property (abort |=> !r.cmd && !r.status && r.phase == PH_IDLE && $stable(r.result))
    else $error("low-power entry did not abort cleanly");

  a_result_hold:
    assert property (r.done && $past(r.done) |-> $stable(r.result))
    else $error("result changed while done set");

  a_ext_start:
    assert property (ext_edge && start_ok && !abort |=> r.cmd && r.phase == PH_INIT)
    else $error("pin edge did not start conversion");

  a_sw_start:
    assert property (sw_start && start_ok && !mc_tick |=> r.cmd && r.phase == PH_IDLE)
    else $error("software start not held for next cycle");

  // interrupt line follows the masked sticky bits one clock later
  a_irq_raise:
    assert property ((|(r.istat & r.imask)) |=> r.irq)
    else $error("interrupt not raised for pending event");

  a_irq_drop:
    assert property (!(|(r.istat & r.imask)) |=> !r.irq)
    else $error("interrupt raised with nothing pending");

  // the approximation register is loaded as sampling closes
  a_sar_load:
    assert property ($fell(r.sample) && !$past(abort) |-> dac_code_o == `SAC_SAR_MSB_ONLY)
    else $error("trial code not msb only at conversion start");

  // with the pin disabled only a software write may set the command flop
  a_pin_ignored:
    assert property (!r.ext_en && !sw_start |=> !$rose(r.cmd))
    else $error("start without software set while pin disabled");

  // the readable status never outlives the command flop
  a_status_cmd:
    assert property (r.status |-> r.cmd)
    else $error("status flag set without command flop");

  // low-power requests keep the converter quiet from the next clock on
  a_lowpower_quiet:
    assert property (r.idle_req || r.pdown_req |=> !r.status && !r.sample)
    else $error("conversion running during low-power request");

  c_sw_start: cover property (sw_start && start_ok);
  c_conv_done: cover property ($rose(r.done));
  c_ext_start: cover property (ext_edge && start_ok);
  c_abort: cover property (abort);
  c_clear_done: cover property (r.done ##[1:40] !r.done);
endmodule : sac_top
`default_nettype wire

// ==== verification/sac_afe_model.sv ====
// sac_afe_model.sv - analog front end: channel mux, sample hold and comparator
// assumes: driven by sac_top sample, select and trial code on mclk_i
`timescale 1ns/1ps
`default_nettype none
module sac_afe_model (
  // clock
  input wire logic mclk_i,
  // one 10-bit level per channel, channel 0 in the low bits
  input wire logic [79:0] vin_i,
  // converter control side
  input wire logic [2:0] sel_i,
  input wire logic sample_i,
  input wire logic [9:0] dac_i,
  output logic comp_o
);
  // ------------------------------------------------------------
  // sample and compare
  // ------------------------------------------------------------
  logic [9:0] held_r = 10'h000; // level kept on the hold capacitor
  initial comp_o = 1'b0;
  // the hold tracks the mux only while sampling, so a late channel change cannot leak in
  always @(posedge mclk_i) begin
    if (sample_i) begin
      held_r <= vin_i[sel_i*10 +: 10];
    end
    comp_o <= held_r > dac_i;
  end
endmodule : sac_afe_model
`default_nettype wire

// ==== verification/testbench.sv ====
// testbench.sv - register-level tests of the converter control
// assumes: sac_top with avalon-mm slave, sac_afe_model as analog side
`timescale 1ns/1ps
`default_nettype none
`include "sac_consts.svh"
module testbench;
  // ------------------------------------------------------------
  // signals and instances
  // ------------------------------------------------------------
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [9:0] avs_address_i = 10'h000;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [3:0] avs_byteenable_i = 4'h0;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic pin = 1'b1; // trigger pin idles high
  logic comp;
  logic [2:0] sel;
  logic sample_o;
  logic [9:0] dac;
  logic irq_o;
  // channel levels, channel 7 first; both ends of the scale included
  logic [79:0] vin = {10'h30c, 10'h0f0, 10'h200, 10'h001, 10'h155, 10'h2a6, 10'h3ff, 10'h000};
  int err_total = 0;
  int compares = 0;
  int cyc = 0; // free-running clock count for timing checks
  logic [9:0] last_res = 10'h000; // result of the last conversion run by conv
  always #50 mclk_i = ~mclk_i;
  always @(posedge mclk_i) cyc <= cyc + 1;
  sac_top dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .external_trigger_pin_i(pin), .comparator_i(comp),
    .analog_input_port_sel_o(sel), .sample_o(sample_o), .dac_code_o(dac), .irq_o(irq_o));
  sac_afe_model afe (.mclk_i(mclk_i), .vin_i(vin), .sel_i(sel), .sample_i(sample_o),
    .dac_i(dac), .comp_o(comp));
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task end_of_test;
    $display("errors %0d compares %0d", err_total, compares);
    if (err_total == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_of_test
  task check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // one avalon cycle; the leading edge keeps the release and the next request apart
  task bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd, input logic [3:0] be,
    output logic [31:0] rd);
    @(posedge mclk_i);
    avs_address_i <= {idx, 2'b00};
    avs_read_i <= !wr;
    avs_write_i <= wr;
    avs_writedata_i <= {24'h0, wd};
    avs_byteenable_i <= be;
    // no local limit: only the watchdog ends a wait that is never answered
    do begin
      @(posedge mclk_i);
    end while (avs_waitrequest_o !== 1'b0);
    rd = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask : bus
  task wr(input logic [7:0] idx, input logic [7:0] wd);
    logic [31:0] x;
    bus(1'b1, idx, wd, 4'h1, x);
  endtask : wr
  task rd(input logic [7:0] idx, output logic [31:0] d);
    bus(1'b0, idx, 8'h00, 4'h1, d);
  endtask : rd
  // bounded wait for sample_o (irq_sel 0) or irq_o (irq_sel 1) to reach lvl
  task till(input logic irq_sel, input logic lvl);
    int n;
    n = 0;
    while (((irq_sel ? irq_o : sample_o) !== lvl) && n < 1000) begin
      @(posedge mclk_i);
      n++;
    end
    if ((irq_sel ? irq_o : sample_o) !== lvl) begin
      err_total++; // level never reached counts as a mismatch
    end
  endtask : till
  // keep-if-greater approximation of an integer level ends one code low
  function automatic logic [9:0] exp_res(input logic [9:0] v);
    return (v == 10'h000) ? 10'h000 : v - 10'h001;
  endfunction : exp_res
  task clr(input logic [2:0] c);
    logic [31:0] d;
    wr(`SAC_IDX_CTRL, {5'h00, c});
    wr(`SAC_IDX_ISTAT, 8'h03);
    rd(`SAC_IDX_ISTAT, d);
    check(d, 32'h0);
    check(irq_o, 1'b0);
  endtask : clr
  // software conversion with phase timing, ignored restart and result placement
  task conv(input logic [2:0] c, output logic [9:0] e);
    logic [31:0] d;
    int t;
    e = exp_res(vin[c*10 +: 10]);
    wr(`SAC_IDX_CTRL, {5'h01, c});
    till(1'b0, 1'b1);
    t = cyc;
    till(1'b0, 1'b0);
    check(32'(cyc - t), 32'd96);
    t = cyc;
    wr(`SAC_IDX_CTRL, {5'h01, c});
    wr(`SAC_IDX_CTRL, {5'h00, c});
    rd(`SAC_IDX_CTRL, d);
    // bits 7:6 still hold the low bits of the previous result until this one is done
    check(d, {24'h0, last_res[1:0], 3'b001, c});
    till(1'b1, 1'b1);
    check(32'(cyc - t), 32'd481);
    rd(`SAC_IDX_RESULT, d);
    check(d, {24'h0, e[9:2]});
    rd(`SAC_IDX_CTRL, d);
    check(d, {24'h0, e[1:0], 3'b010, c});
    last_res = e;
  endtask : conv
  // ------------------------------------------------------------
  // main sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    repeat (40000) @(posedge mclk_i);
    err_total++;
    end_of_test;
  end
  initial begin
    logic [31:0] d;
    logic [9:0] e;
    repeat (20) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    rd(`SAC_IDX_CTRL, d);
    check(d, 32'h0);
    rd(8'h10, d);
    check(d, 32'h0);
    bus(1'b1, `SAC_IDX_CTRL, 8'h0d, 4'he, d);
    rd(`SAC_IDX_CTRL, d);
    check(d, 32'h0);
    wr(`SAC_IDX_IMASK, 8'h01);
    for (int c = 0; c < 8; c++) begin
      conv(3'(c), e);
      if (c == 7) begin
        rd(`SAC_IDX_ISTAT, d);
        check(d, 32'h1);
        wr(`SAC_IDX_IMASK, 8'h00);
        rd(`SAC_IDX_RESULT, d);
        check(irq_o, 1'b0);
        wr(`SAC_IDX_IMASK, 8'h01);
        rd(`SAC_IDX_RESULT, d);
        check(irq_o, 1'b1);
        wr(`SAC_IDX_CTRL, 8'h1f);
        repeat (40) @(posedge mclk_i);
        rd(`SAC_IDX_CTRL, d);
        check(d, {24'h0, e[1:0], 6'h17});
        wr(`SAC_IDX_POWER, 8'h01);
        rd(`SAC_IDX_RESULT, d);
        check(d, {24'h0, e[9:2]});
        rd(`SAC_IDX_CTRL, d);
        check(d, {24'h0, e[1:0], 6'h17});
        wr(`SAC_IDX_POWER, 8'h00);
      end
      clr(3'(c));
    end
    // pin edge starts only with external start enabled
    for (int x = 0; x < 2; x++) begin
      wr(`SAC_IDX_CTRL, {2'b00, 1'(x), 5'h02});
      pin <= 1'b0;
      repeat (30) @(posedge mclk_i);
      pin <= 1'b1;
      repeat (40) @(posedge mclk_i);
      rd(`SAC_IDX_CTRL, d);
      check(d[5:0], {1'(x), 1'b0, 1'(x), 3'h2});
      if (x == 1) begin
        till(1'b1, 1'b1);
        e = exp_res(vin[29:20]);
        rd(`SAC_IDX_RESULT, d);
        check(d, {24'h0, e[9:2]});
        clr(3'h2);
      end
    end
    // power-down mid-sampling aborts and blocks new starts
    wr(`SAC_IDX_CTRL, 8'h0b);
    till(1'b0, 1'b1);
    wr(`SAC_IDX_POWER, 8'h02);
    rd(`SAC_IDX_CTRL, d);
    check(d[5:0], 6'h03);
    check(sample_o, 1'b0);
    rd(`SAC_IDX_ISTAT, d);
    check(d, 32'h2);
    wr(`SAC_IDX_CTRL, 8'h0b);
    repeat (40) @(posedge mclk_i);
    rd(`SAC_IDX_CTRL, d);
    check(d[5:0], 6'h03);
    check(irq_o, 1'b0);
    wr(`SAC_IDX_POWER, 8'h00);
    end_of_test;
  end
endmodule : testbench
`default_nettype wire
